/* File: rtl/uart_status_regs_defines.vh */
`ifndef UART_STATUS_REGS_DEFINES_VH
`define UART_STATUS_REGS_DEFINES_VH
`define OFS_LINE_STATUS 3'h0
`define OFS_DATA_PORT 3'h1
`define OFS_BAUD_MIDDLE 3'h2
`define OFS_BAUD_OUTER 3'h3
`define OFS_CTRL_A 3'h4
`define OFS_CTRL_B 3'h5
`define OFS_CTRL_C 3'h6
`define ADDR_W 3
`define STATUS_RESET 8'hC0
`define BIT_TXE 7
`define BIT_TC 6
`define BIT_RX_NOT_EMPTY 5
`define BIT_IDLE 4
`define BIT_OR 3
`define BIT_NF 2
`define BIT_FE 1
`define BIT_PE 0
`define BIT_PARITY_IRQ_ENABLE 0
`define BIT_TX_EMPTY_IRQ_ENABLE 7
`define BIT_TX_COMPLETE_IRQ_ENABLE 6
`define BIT_RX_IRQ_ENABLE 5
`define BIT_IDLE_IRQ_ENABLE 4
`define BIT_TEN 3
`define BIT_REN 2
`define BIT_BREAK_IRQ_ENABLE 0
`define BIT_HEADER_IRQ_ENABLE 1
`define BIT_LIN_SLAVE 2
`define BIT_AUTO_RESYNC_ENABLE 3
`endif

/* File: rtl/uart_status_regs.v */
// How it works
// - In Wait the block runs on; enabled interrupts raise the wake output.
// - Halt freezes every register and stops transmit and receive.
// - Two request lines: transmit group and receive group.
// - Each event requests only with its enable; core masks globally.
// - Transmit-empty sets on buffer-to-shifter move, clears on data write.
// - Transmit-complete sets at frame end with empty; status read+write or 0.
// - Receive-not-empty sets on word arrival; clears on data read or 0.
// - Idle sets on idle; two-step clear; rearmed only by new word.
// - Overrun keeps buffered word, sets flag; two-step clear.
// - In LIN slave mode bit 3 also reports header errors.
// - Noise sets on noisy frame, no own request; two-step clear.
// - Framing sets on desync/noise/break; LIN slave never on break.
// - Framing with overrun on one word: only overrun sets.
// - Parity sets on parity or identifier parity error; requests when on.
// - Data read gives receive buffer; write loads transmit buffer.
// - One divider both ways; counters reload on middle-byte write.
// - Transmit/receive baud counters halt while their enable is clear.
// - Middle byte holds divider 11:4; zero disables the baud clock.
// - Outer register holds divider 15:12 high and 3:0 low.
// - Idle requests only with idle-line enable set.
//
// Decided for this implementation: strobed register access.
`include "uart_status_regs_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module uart_status_regs (
  input wire clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire halt_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire tx_load_i,
  input wire tx_frame_done_i,
  input wire rx_word_i,
  input wire [7:0] rx_data_i,
  input wire rx_idle_i,
  input wire rx_noise_i,
  input wire rx_frame_err_i,
  input wire rx_break_i,
  input wire rx_parity_err_i,
  input wire lin_header_err_i,
  input wire lin_deviation_err_i,
  input wire lin_break_det_i,
  input wire lin_header_det_i,
  output reg [7:0] tx_holding_buffer_o,
  output reg [15:0] baud_div_o,
  output reg baud_reload_o,
  output reg tx_baud_run_o,
  output reg rx_baud_run_o,
  output reg xfer_run_o,
  output reg tx_irq_o,
  output reg rx_irq_o,
  output reg wake_o
);
  reg tx_buffer_empty_q, tx_complete_q, rx_not_empty_q, idle_q;
  reg ovr_q, noise_flag_q, framing_error_flag_q, parity_error_flag_q;
  reg break_detect_flag_q, header_detect_flag_q, idle_armed_q;
  reg sr_read_q;
  reg [7:0] rx_holding_buffer_q;
  reg [7:0] baud_div_middle_q, baud_div_outer_q;
  reg [7:0] ctrl_a_q, ctrl_b_q, ctrl_c_q;
  wire run = clk_en_i & ~halt_i;
  wire lin_slave = ctrl_c_q[`BIT_LIN_SLAVE];
  wire wr_dr = run & wr_i & (addr_i == `OFS_DATA_PORT);
  wire rd_dr = run & rd_i & (addr_i == `OFS_DATA_PORT);
  wire rd_sr = run & rd_i & (addr_i == `OFS_LINE_STATUS);
  wire wr_sr = run & wr_i & (addr_i == `OFS_LINE_STATUS);
  wire seq_rd = rd_dr & sr_read_q;
  wire seq_wr = wr_dr & sr_read_q;
  wire rx_ev = run & rx_word_i;
  wire overrun = rx_ev & rx_not_empty_q;
  wire hdr_err = lin_header_err_i | (lin_deviation_err_i & ctrl_c_q[`BIT_AUTO_RESYNC_ENABLE]);
  wire fe_set = run & ((rx_ev & rx_frame_err_i & ~overrun)
    | (~lin_slave & rx_break_i));
  wire [7:0] status = {tx_buffer_empty_q, tx_complete_q, rx_not_empty_q,
    idle_q, ovr_q, noise_flag_q, framing_error_flag_q, parity_error_flag_q};
  wire tx_req = (tx_buffer_empty_q & ctrl_b_q[`BIT_TX_EMPTY_IRQ_ENABLE])
    | (tx_complete_q & ctrl_b_q[`BIT_TX_COMPLETE_IRQ_ENABLE]);
  wire rx_req = ((rx_not_empty_q | ovr_q) & ctrl_b_q[`BIT_RX_IRQ_ENABLE])
    | (idle_q & ctrl_b_q[`BIT_IDLE_IRQ_ENABLE])
    | (parity_error_flag_q & ctrl_a_q[`BIT_PARITY_IRQ_ENABLE])
    | (break_detect_flag_q & ctrl_c_q[`BIT_BREAK_IRQ_ENABLE])
    | (header_detect_flag_q & ctrl_c_q[`BIT_HEADER_IRQ_ENABLE]);
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      {tx_buffer_empty_q, tx_complete_q} <= 2'h3;
      {rx_not_empty_q, idle_q, ovr_q, noise_flag_q} <= 4'h0;
      {framing_error_flag_q, parity_error_flag_q} <= 2'h0;
      {break_detect_flag_q, header_detect_flag_q} <= 2'h0;
      idle_armed_q <= 1'b0;
      sr_read_q <= 1'b0;
      rx_holding_buffer_q <= 8'h00;
      tx_holding_buffer_o <= 8'h00;
      baud_div_middle_q <= 8'h00;
      baud_div_outer_q <= 8'h00;
      ctrl_a_q <= 8'h00;
      ctrl_b_q <= 8'h00;
      ctrl_c_q <= 8'h00;
      rdata_o <= 8'h00;
      baud_div_o <= 16'h0000;
      baud_reload_o <= 1'b0;
      tx_baud_run_o <= 1'b0;
      rx_baud_run_o <= 1'b0;
      xfer_run_o <= 1'b0;
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else if (clk_en_i) begin
      xfer_run_o <= ~halt_i;
      baud_reload_o <= run & wr_i & (addr_i == `OFS_BAUD_MIDDLE);
      baud_div_o <= {baud_div_outer_q[7:4], baud_div_middle_q,
        baud_div_outer_q[3:0]};
      tx_baud_run_o <= ctrl_b_q[`BIT_TEN] & (baud_div_middle_q != 8'h00);
      rx_baud_run_o <= ctrl_b_q[`BIT_REN] & (baud_div_middle_q != 8'h00);
      tx_irq_o <= tx_req;
      rx_irq_o <= rx_req;
      wake_o <= (tx_req | rx_req) & ~halt_i;
      if (run) begin
        if (rd_i) begin
          case (addr_i)
            `OFS_LINE_STATUS: rdata_o <= status;
            `OFS_DATA_PORT: rdata_o <= rx_holding_buffer_q;
            `OFS_BAUD_MIDDLE: rdata_o <= baud_div_middle_q;
            `OFS_BAUD_OUTER: rdata_o <= baud_div_outer_q;
            `OFS_CTRL_A: rdata_o <= ctrl_a_q;
            `OFS_CTRL_B: rdata_o <= ctrl_b_q;
            `OFS_CTRL_C: rdata_o <= {break_detect_flag_q, header_detect_flag_q,
              2'h0, ctrl_c_q[3:0]};
            default: rdata_o <= 8'h00;
          endcase
        end
        if (wr_i) begin
          case (addr_i)
            `OFS_BAUD_MIDDLE: baud_div_middle_q <= wdata_i;
            `OFS_BAUD_OUTER: baud_div_outer_q <= wdata_i;
            `OFS_CTRL_A: ctrl_a_q <= wdata_i;
            `OFS_CTRL_B: ctrl_b_q <= wdata_i;
            `OFS_CTRL_C: ctrl_c_q <= {4'h0, wdata_i[3:0]};
            default: ctrl_c_q <= ctrl_c_q;
          endcase
        end
        if (wr_dr)
          tx_holding_buffer_o <= wdata_i;
        if (rd_sr)
          sr_read_q <= 1'b1;
        else if (rd_dr | wr_dr)
          sr_read_q <= 1'b0;
        if (tx_load_i)
          tx_buffer_empty_q <= 1'b1;
        else if (wr_dr)
          tx_buffer_empty_q <= 1'b0;
        if (tx_frame_done_i & tx_buffer_empty_q)
          tx_complete_q <= 1'b1;
        else if (seq_wr | (wr_sr & ~wdata_i[`BIT_TC]))
          tx_complete_q <= 1'b0;
        if (rx_ev & ~rx_not_empty_q)
          rx_holding_buffer_q <= rx_data_i;
        if (rx_ev)
          rx_not_empty_q <= 1'b1;
        else if (rd_dr | (wr_sr & ~wdata_i[`BIT_RX_NOT_EMPTY]))
          rx_not_empty_q <= 1'b0;
        if (rx_ev)
          idle_armed_q <= 1'b1;
        else if (rx_idle_i & idle_armed_q)
          idle_armed_q <= 1'b0;
        if (rx_idle_i & idle_armed_q)
          idle_q <= 1'b1;
        else if (seq_rd)
          idle_q <= 1'b0;
        if (overrun | (lin_slave & hdr_err))
          ovr_q <= 1'b1;
        else if (seq_rd)
          ovr_q <= 1'b0;
        if (rx_ev & rx_noise_i)
          noise_flag_q <= 1'b1;
        else if (seq_rd)
          noise_flag_q <= 1'b0;
        if (fe_set)
          framing_error_flag_q <= 1'b1;
        else if (seq_rd)
          framing_error_flag_q <= 1'b0;
        if (rx_parity_err_i)
          parity_error_flag_q <= 1'b1;
        else if (seq_rd)
          parity_error_flag_q <= 1'b0;
        if (lin_break_det_i)
          break_detect_flag_q <= 1'b1;
        else if (wr_i & (addr_i == `OFS_CTRL_C) & ~wdata_i[7])
          break_detect_flag_q <= 1'b0;
        if (lin_header_det_i)
          header_detect_flag_q <= 1'b1;
        else if (wr_i & (addr_i == `OFS_CTRL_C) & ~wdata_i[6])
          header_detect_flag_q <= 1'b0;
      end
    end
  end
endmodule // uart_status_regs
`default_nettype wire

/* File: tb/uart_status_regs_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module uart_status_regs_chk (
  input wire logic clk_i, sys_rst_i, clk_en_i, halt_i, wr_i, rd_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i, rdata_o, tx_holding_buffer_o,
  input wire logic [15:0] baud_div_o,
  input wire logic baud_reload_o, tx_baud_run_o, rx_baud_run_o,
  input wire logic xfer_run_o, tx_irq_o, rx_irq_o, wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic run = clk_en_i && !halt_i;
  wire logic mid_wr = run && wr_i && addr_i == 3'h2;
  chk_halt_stops: assert property (halt_i && clk_en_i |=> !xfer_run_o)
    else $error("transfer runs in halt");
  chk_frozen_regs: assert property (!run |=> $stable(baud_div_o)
    && $stable(tx_holding_buffer_o)) else $error("register moved");
  chk_reload_pulse: assert property (mid_wr |=> baud_reload_o)
    else $error("no reload");
  chk_reload_cause: assert property (baud_reload_o |-> $past(mid_wr))
    else $error("stray reload");
  chk_middle_bits: assert property (mid_wr |-> ##2
    baud_div_o[11:4] == $past(wdata_i, 2)) else $error("divider bits");
  chk_tx_buffer: assert property (run && wr_i && addr_i == 3'h1
    |=> tx_holding_buffer_o == $past(wdata_i)) else $error("tx buffer");
  chk_rdata_stands: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved");
  chk_zero_divider: assert property (baud_div_o[11:4] == 8'h00
    |-> !tx_baud_run_o && !rx_baud_run_o)
    else $error("baud runs at zero");
  chk_wake_follows: assert property ($rose(tx_irq_o || rx_irq_o)
    && !halt_i |-> ##[0:1] wake_o) else $error("no wake");
  cover property (mid_wr);
  cover property (rx_irq_o && wake_o);
  cover property (tx_irq_o);
endmodule // uart_status_regs_chk
bind uart_status_regs uart_status_regs_chk i_uart_status_regs_chk (
  .clk_i, .sys_rst_i, .clk_en_i, .halt_i, .wr_i, .rd_i, .addr_i, .wdata_i,
  .rdata_o, .tx_holding_buffer_o, .baud_div_o, .baud_reload_o,
  .tx_baud_run_o, .rx_baud_run_o, .xfer_run_o, .tx_irq_o, .rx_irq_o,
  .wake_o);
`default_nettype wire

/* File: tb/remote_node.sv */
`timescale 1ns/100ps
`default_nettype none
module remote_node (
  input wire logic clk_i,
  output logic rx_word_o, rx_idle_o, rx_noise_o, rx_frame_err_o,
  output logic rx_parity_err_o,
  output logic [7:0] rx_data_o
);
  initial {rx_word_o, rx_idle_o, rx_noise_o, rx_frame_err_o} = 4'h0;
  initial {rx_parity_err_o, rx_data_o} = 9'h0;
  // Error bits are {parity, framing, noise}; data shows junk after, errors
  // drop so a stray parity pulse cannot land outside a word
  task automatic send(input logic [7:0] d, input logic [2:0] e);
    @(posedge clk_i);
    rx_word_o <= 1'b1;
    rx_data_o <= d;
    {rx_parity_err_o, rx_frame_err_o, rx_noise_o} <= e;
    @(posedge clk_i);
    rx_word_o <= 1'b0;
    rx_data_o <= ~d;
    {rx_parity_err_o, rx_frame_err_o, rx_noise_o} <= 3'h0;
  endtask
  task automatic idle;
    @(posedge clk_i);
    rx_idle_o <= 1'b1;
    @(posedge clk_i);
    rx_idle_o <= 1'b0;
  endtask
endmodule // remote_node
`default_nettype wire

/* File: tb/uart_status_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module uart_status_regs_tb;
  logic clk_i, sys_rst_i, clk_en_i, halt_i, wr_i, rd_i, tx_load_i;
  logic tx_frame_done_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rx_data_i;
  logic [7:0] rdata_o, tx_holding_buffer_o;
  logic [15:0] baud_div_o;
  logic rx_word_i, rx_idle_i, rx_noise_i, rx_frame_err_i, rx_parity_err_i;
  logic baud_reload_o, tx_baud_run_o, rx_baud_run_o, xfer_run_o;
  logic tx_irq_o, rx_irq_o, wake_o;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  uart_status_regs i_uart_status_regs (.clk_i, .sys_rst_i, .clk_en_i,
    .halt_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .tx_load_i,
    .tx_frame_done_i, .rx_word_i, .rx_data_i, .rx_idle_i, .rx_noise_i,
    .rx_frame_err_i, .rx_break_i(1'b0), .rx_parity_err_i,
    .lin_header_err_i(1'b0), .lin_deviation_err_i(1'b0),
    .lin_break_det_i(1'b0), .lin_header_det_i(1'b0), .tx_holding_buffer_o,
    .baud_div_o, .baud_reload_o, .tx_baud_run_o, .rx_baud_run_o,
    .xfer_run_o, .tx_irq_o, .rx_irq_o, .wake_o);
  remote_node i_remote_node (.clk_i, .rx_word_o(rx_word_i),
    .rx_idle_o(rx_idle_i), .rx_noise_o(rx_noise_i),
    .rx_frame_err_o(rx_frame_err_i), .rx_parity_err_o(rx_parity_err_i),
    .rx_data_o(rx_data_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test;
    end
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      $display("mismatch %s exp %h got %h", n, e, s);
      n_errors++;
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk("rdata", {8'h00, e}, {8'h00, rdata_o});
  endtask
  task shift;
    @(posedge clk_i);
    tx_load_i <= 1'b1;
    @(posedge clk_i);
    tx_load_i <= 1'b0;
    tx_frame_done_i <= 1'b1;
    @(posedge clk_i);
    tx_frame_done_i <= 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  initial begin
    {sys_rst_i, clk_en_i, halt_i, wr_i, rd_i} = 5'h18;
    {tx_load_i, tx_frame_done_i, addr_i, wdata_i} = 13'h0;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rc(3'h0, 8'hC0);
    rc(3'h2, 8'h00);
    rc(3'h7, 8'h00);
    wr(3'h5, 8'h2C);
    wr(3'h3, 8'hA5);
    wr(3'h2, 8'h3C);
    repeat (3) @(negedge clk_i);
    chk("divider", 16'hA3C5, baud_div_o);
    chk("tx_run", 16'h1, tx_baud_run_o);
    chk("rx_run", 16'h1, rx_baud_run_o);
    rc(3'h0, 8'hC0);
    wr(3'h1, 8'h5A);
    rc(3'h0, 8'h00);
    shift;
    chk("tx_irq", 16'h0, tx_irq_o);
    rc(3'h0, 8'hC0);
    wr(3'h5, 8'hAC);
    repeat (2) @(negedge clk_i);
    chk("tx_irq", 16'h1, tx_irq_o);
    i_remote_node.send(8'h81, 3'h1);
    repeat (2) @(negedge clk_i);
    chk("rx_irq", 16'h1, rx_irq_o);
    chk("wake", 16'h1, wake_o);
    rc(3'h0, 8'hE4);
    rc(3'h1, 8'h81);
    rc(3'h0, 8'hC0);
    i_remote_node.send(8'h11, 3'h0);
    i_remote_node.send(8'h22, 3'h2);
    rc(3'h0, 8'hE8);
    rc(3'h1, 8'h11);
    i_remote_node.send(8'h33, 3'h4);
    rc(3'h0, 8'hE1);
    rc(3'h1, 8'h33);
    wr(3'h5, 8'h2C);
    i_remote_node.idle;
    repeat (2) @(negedge clk_i);
    chk("rx_irq", 16'h0, rx_irq_o);
    rc(3'h0, 8'hD0);
    rc(3'h1, 8'h33);
    i_remote_node.idle;
    rc(3'h0, 8'hC0);
    wr(3'h0, 8'h00);
    rc(3'h0, 8'h80);
    @(posedge clk_i);
    halt_i <= 1'b1;
    wr(3'h1, 8'hEE);
    @(negedge clk_i);
    chk("xfer_run", 16'h0, xfer_run_o);
    @(posedge clk_i);
    halt_i <= 1'b0;
    @(negedge clk_i);
    chk("tx_buf", 16'h5A, tx_holding_buffer_o);
    end_of_test;
  end
endmodule // uart_status_regs_tb
`default_nettype wire
